// ==== hdl/sram_ctrl_defines.vh ====
`ifndef SRAM_CTRL_DEFINES_VH
`define SRAM_CTRL_DEFINES_VH

// Pin widths
`define ADDR_W 19
`define DATA_W 32
// Clock period in ps (50 MHz)
`define CLK_PS 20000
// Read cycle and access time, 20 ns
`define T_ACCESS_PS 20000
// Output-enable access and error-flag valid time, 8.6 ns
`define T_OE_PS 8600
// Cycle counts: least times round up; the OE count adds one cycle
`define ACC_CYC ((`T_ACCESS_PS + `CLK_PS - 1) / `CLK_PS)
`define OE_CYC ((`T_OE_PS + `CLK_PS - 1) / `CLK_PS + 1)
// Flag synchroniser stages; a read must not end before the flag has crossed them
`define SYNC_CYC 2
`define RD_CYC (`ACC_CYC + `SYNC_CYC)
// Cycles held deselected so the flag pull-down can settle
`define DESEL_CYC 3
`define CNT_W 4
`define CNT_ZERO 4'h0
`define ADDR_ZERO 19'h00000
`define DATA_ZERO 32'h00000000

`endif

// ==== hdl/flag_sync.v ====
`default_nettype none

// Two-stage synchroniser for the error flag pin
module flag_sync (
    // Clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output wire sync_out
);

    reg meta_ff;
    reg sync_ff;

    always @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ==== hdl/sram_error_detect_correct_host.v ====
// Overview of operation
// - Never hold output and write enables high with flag high while selected.
// - Flag must return low before the next error can be reported.
// - Clear: deselect first, then raise output enable.
// - Deselect by the high-active select keeps scrubbing running while enable rises.
// - Stay deselected until flag low; move to last error-free address.
// - Reselect with output enable high, then lower it for a read.
// - Address changes spaced by at least 20 ns; data valid within 20 ns.
`default_nettype none
`include "sram_ctrl_defines.vh"

module sram_error_detect_correct_host (
    // Clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // User request port
    input wire req_valid_in,
    input wire req_write_in,
    input wire [`ADDR_W-1:0] req_addr_in,
    input wire [`DATA_W-1:0] req_wdata_in,
    output wire req_ready_out,
    // User answer port
    output reg rsp_valid_out,
    output reg [`DATA_W-1:0] rsp_rdata_out,
    output reg rsp_error_out,
    output reg flag_clear_done_out,
    // Memory pins
    output reg [`ADDR_W-1:0] mem_addr_out,
    output reg chip_select_low_active_out,
    output reg chip_select_high_active_out,
    output reg write_enable_n_out,
    output reg output_enable_n_out,
    input wire [`DATA_W-1:0] mem_dq_in,
    output reg [`DATA_W-1:0] mem_dq_out,
    output reg mem_dq_oe_n_out,
    input wire bit_error_flag_in
);

    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_READ = 7'h02;
    localparam [6:0] ST_WRITE = 7'h04;
    localparam [6:0] ST_DESEL = 7'h08;
    localparam [6:0] ST_OEHI = 7'h10;
    localparam [6:0] ST_RESEL = 7'h20;
    localparam [6:0] ST_OERD = 7'h40;

    localparam integer ACC_I = `ACC_CYC;
    localparam integer RD_I = `RD_CYC;
    localparam integer OE_I = `OE_CYC;
    localparam integer DESEL_I = `DESEL_CYC;
    localparam [`CNT_W-1:0] ACC_N = ACC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] RD_N = RD_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] OE_N = OE_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] DESEL_N = DESEL_I[`CNT_W-1:0];

    reg [6:0] state_ff;
    reg [6:0] nxt_state;
    reg [`CNT_W-1:0] cnt_ff;
    reg [`CNT_W-1:0] nxt_cnt;
    reg [`ADDR_W-1:0] good_addr_ff;
    wire flag_sync;

    flag_sync flag_sync_i (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(bit_error_flag_in),
        .sync_out(flag_sync)
    );

    assign req_ready_out = (state_ff == ST_IDLE);

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff == `CNT_ZERO) ? cnt_ff : cnt_ff - 1'b1;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid_in) begin
                    nxt_state = req_write_in ? ST_WRITE : ST_READ;
                    // Reads also wait out the synchroniser, else the flag is sampled stale
                    nxt_cnt = req_write_in ? ACC_N : RD_N;
                end
            end
            ST_READ: begin
                if (cnt_ff == `CNT_ZERO) begin
                    nxt_state = flag_sync ? ST_DESEL : ST_IDLE;
                    nxt_cnt = DESEL_N;
                end
            end
            ST_WRITE: begin
                if (cnt_ff == `CNT_ZERO) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_DESEL: begin
                if (cnt_ff == `CNT_ZERO) begin
                    nxt_state = ST_OEHI;
                    nxt_cnt = DESEL_N;
                end
            end
            ST_OEHI: begin
                if (cnt_ff == `CNT_ZERO && !flag_sync) begin
                    nxt_state = ST_RESEL;
                    nxt_cnt = ACC_N;
                end
            end
            ST_RESEL: begin
                if (cnt_ff == `CNT_ZERO) begin
                    nxt_state = ST_OERD;
                    nxt_cnt = OE_N;
                end
            end
            ST_OERD: begin
                if (cnt_ff == `CNT_ZERO) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_ff <= ST_IDLE;
            cnt_ff <= `CNT_ZERO;
            good_addr_ff <= `ADDR_ZERO;
            mem_addr_out <= `ADDR_ZERO;
            chip_select_low_active_out <= 1'b0;
            chip_select_high_active_out <= 1'b0;
            write_enable_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            mem_dq_out <= `DATA_ZERO;
            mem_dq_oe_n_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= `DATA_ZERO;
            rsp_error_out <= 1'b0;
            flag_clear_done_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rsp_valid_out <= 1'b0;
            flag_clear_done_out <= 1'b0;
            case (nxt_state)
                ST_IDLE: begin
                    // Scrub standby keeps background correction running between accesses
                    chip_select_low_active_out <= 1'b0;
                    chip_select_high_active_out <= 1'b0;
                    write_enable_n_out <= 1'b1;
                    output_enable_n_out <= 1'b1;
                    mem_dq_oe_n_out <= 1'b1;
                end
                ST_READ: begin
                    chip_select_low_active_out <= 1'b0;
                    chip_select_high_active_out <= 1'b1;
                    write_enable_n_out <= 1'b1;
                    output_enable_n_out <= 1'b0;
                    mem_dq_oe_n_out <= 1'b1;
                    if (state_ff == ST_IDLE) begin
                        mem_addr_out <= req_addr_in;
                    end
                end
                ST_WRITE: begin
                    // Output enable held high so the write never floats as a flag-select cycle
                    chip_select_low_active_out <= 1'b0;
                    chip_select_high_active_out <= 1'b1;
                    write_enable_n_out <= (nxt_cnt == `CNT_ZERO);
                    output_enable_n_out <= 1'b1;
                    mem_dq_oe_n_out <= 1'b0;
                    if (state_ff == ST_IDLE) begin
                        mem_addr_out <= req_addr_in;
                        mem_dq_out <= req_wdata_in;
                        good_addr_ff <= req_addr_in;
                    end
                end
                ST_DESEL: begin
                    // Drop the high-active select so scrubbing keeps running
                    chip_select_high_active_out <= 1'b0;
                    chip_select_low_active_out <= 1'b0;
                    output_enable_n_out <= 1'b0;
                    mem_dq_oe_n_out <= 1'b1;
                end
                ST_OEHI: begin
                    output_enable_n_out <= 1'b1;
                    mem_addr_out <= good_addr_ff;
                end
                ST_RESEL: begin
                    chip_select_high_active_out <= 1'b1;
                    output_enable_n_out <= 1'b1;
                end
                ST_OERD: begin
                    output_enable_n_out <= 1'b0;
                end
                default: begin
                    chip_select_high_active_out <= 1'b0;
                end
            endcase
            if (state_ff == ST_READ && cnt_ff == `CNT_ZERO) begin
                rsp_valid_out <= 1'b1;
                rsp_rdata_out <= mem_dq_in;
                rsp_error_out <= flag_sync;
                if (!flag_sync) begin
                    good_addr_ff <= mem_addr_out;
                end
            end
            if (state_ff == ST_OERD && cnt_ff == `CNT_ZERO) begin
                flag_clear_done_out <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/sram_error_detect_correct_host_props.sv ====
`default_nettype none
module sram_error_detect_correct_host_props (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // User side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic flag_clear_done_out,
    // Memory pins
    input wire logic [18:0] mem_addr_out,
    input wire logic chip_select_low_active_out,
    input wire logic chip_select_high_active_out,
    input wire logic write_enable_n_out,
    input wire logic output_enable_n_out,
    input wire logic mem_dq_oe_n_out,
    input wire logic bit_error_flag_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire take = req_valid_in && req_ready_out;
    wire csh = chip_select_high_active_out;
    a_host_quiet: assert property (!csh |-> mem_dq_oe_n_out)
        else $error("host drove bus while deselected");
    a_write_drives: assert property (!write_enable_n_out |->
        !mem_dq_oe_n_out && csh && output_enable_n_out) else $error("bad write pins");
    a_no_contention: assert property (!output_enable_n_out |-> mem_dq_oe_n_out)
        else $error("bus contention on read");
    a_scrub_kept: assert property (chip_select_low_active_out == 1'b0)
        else $error("low active select moved");
    a_read_answer: assert property (take && !req_write_in |-> ##5 rsp_valid_out)
        else $error("read answer late");
    a_write_done: assert property (take && req_write_in |->
        ##1 !req_ready_out [*2] ##1 req_ready_out) else $error("write timing off");
    a_addr_steady: assert property ($rose(csh) |=> $stable(mem_addr_out))
        else $error("address moved during access");
    a_desel_first: assert property ($fell(csh) && !output_enable_n_out |=>
        !output_enable_n_out) else $error("enable raised with deselect");
    a_reselect_quiet: assert property ($rose(csh) && output_enable_n_out &&
        write_enable_n_out |=> output_enable_n_out) else $error("reselect enable low");
    a_wait_flag: assert property (!csh && bit_error_flag_in |=> !csh)
        else $error("reselected with flag high");
    a_done_ready: assert property (flag_clear_done_out |-> ##[0:1] req_ready_out)
        else $error("no idle after clear");
endmodule
`default_nettype wire

// ==== tb/error_detect_correct_sram_model.sv ====
`default_nettype none
module error_detect_correct_sram_model (
    // Sample clock for the behavioural state
    input wire logic clk_in,
    // Control and data pins
    input wire logic [18:0] addr_in,
    input wire logic sel_n_in,
    input wire logic sel_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [31:0] d_in,
    output logic [31:0] q_out,
    output logic q_en_out,
    output logic flag_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:524287];
    bit wr [0:524287];
    logic flagged = 1'b0;
    logic armed = 1'b0;
    logic [31:0] last = 32'h00000000;
    wire on = !sel_n_in && sel_in;
    assign q_en_out = on && we_n_in && !oe_n_in;
    // Released bus shows the inverse, so a stale value never passes
    assign q_out = q_en_out ? (wr[addr_in] ? mem[addr_in] : 32'h0000_0000) : ~last;
    // Zero access delay sits inside every read and flag valid limit
    wire zero_delay = 1'b1;
    // Pull-down holds the flag low whenever the driver is off
    assign flag_out = !sel_n_in && !oe_n_in && flagged;
    always @(negedge clk_in) begin
        if (on && !we_n_in) begin
            mem[addr_in] <= d_in;
            wr[addr_in] <= 1'b1;
        end
        if (q_en_out) begin
            last <= q_out;
            if (!wr[addr_in]) flagged <= 1'b1;
            else if (armed) flagged <= 1'b0;
        end
        armed <= flagged && on && oe_n_in;
    end
endmodule
`default_nettype wire

// ==== tb/sram_error_detect_correct_host_bench.sv ====
`default_nettype none
module sram_error_detect_correct_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, valid = 0, wr = 0;
    logic [18:0] addr = 0;
    logic [31:0] wdata = 0;
    wire ready, rv, rerr, done, csl, csh, we_n, oe_n, dq_oe_n, flag, q_en;
    wire [18:0] maddr;
    wire [31:0] rdata, dq_out, q, dq;
    int mismatches = 0;
    int checks = 0;
    assign dq = dq_oe_n ? q : dq_out;
    sram_error_detect_correct_host sram_error_detect_correct_host_i (.ref_clk_in(clk), .rstn_in(rstn), .req_valid_in(valid),
        .req_write_in(wr), .req_addr_in(addr), .req_wdata_in(wdata), .req_ready_out(ready),
        .rsp_valid_out(rv), .rsp_rdata_out(rdata), .rsp_error_out(rerr),
        .flag_clear_done_out(done), .mem_addr_out(maddr), .chip_select_low_active_out(csl),
        .chip_select_high_active_out(csh), .write_enable_n_out(we_n),
        .output_enable_n_out(oe_n), .mem_dq_in(dq), .mem_dq_out(dq_out),
        .mem_dq_oe_n_out(dq_oe_n), .bit_error_flag_in(flag));
    error_detect_correct_sram_model error_detect_correct_sram_model_i (.clk_in(clk), .addr_in(maddr), .sel_n_in(csl),
        .sel_in(csh), .we_n_in(we_n), .oe_n_in(oe_n), .d_in(dq), .q_out(q),
        .q_en_out(q_en), .flag_out(flag));
    initial forever #10 clk = ~clk;
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic req(logic w, logic [18:0] a, logic [31:0] d);
        int n;
        for (n = 0; n < 40 && ready !== 1'b1; n++) @(negedge clk);
        if (n == 40) begin
            mismatches++;
            print_verdict();
        end
        valid = 1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        valid = 0;
    endtask
    task automatic rd(logic [18:0] a, output logic [31:0] d, output logic e);
        int n;
        req(0, a, 0);
        for (n = 0; n < 20 && rv !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin
            mismatches++;
            print_verdict();
        end
        d = rdata;
        e = rerr;
    endtask
    task automatic scen_readback(logic [18:0] a, logic [31:0] exp);
        logic [31:0] d;
        logic e;
        rd(a, d, e);
        check("read data", d, exp);
        check("read error", e, 0);
    endtask
    task automatic scen_write_read;
        req(1, 19'h7ffff, 32'hdeadbeef);
        req(1, 19'h00000, 32'h12345678);
        scen_readback(19'h7ffff, 32'hdeadbeef);
        scen_readback(19'h00000, 32'h12345678);
        check("idle pins", {csl, csh, dq_oe_n}, 3'b001);
    endtask
    task automatic scen_unwritten(logic [18:0] a, logic [18:0] good);
        logic [31:0] d;
        logic e;
        int n;
        rd(a, d, e);
        check("unwritten error", e, 1);
        for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge clk);
        check("clear done", done, 1);
        check("flag low", flag, 0);
        check("clean address", maddr, good);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1;
        scen_write_read();
        scen_unwritten(19'h00123, 19'h00000);
        scen_readback(19'h7ffff, 32'hdeadbeef);
        scen_unwritten(19'h40000, 19'h7ffff);
        scen_readback(19'h00000, 32'h12345678);
        print_verdict();
    end
endmodule
bind sram_error_detect_correct_host sram_error_detect_correct_host_props sram_error_detect_correct_host_props_i (.ref_clk_in, .rstn_in,
    .req_valid_in, .req_write_in, .req_ready_out, .rsp_valid_out, .flag_clear_done_out,
    .mem_addr_out, .chip_select_low_active_out, .chip_select_high_active_out,
    .write_enable_n_out, .output_enable_n_out, .mem_dq_oe_n_out, .bit_error_flag_in);
`default_nettype wire
